// File: mcsc_pkg.sv
// Constants, types and register map for the measurement cycle sequencer.
// Assumes a single 125 MHz clock and an Avalon-MM register bus.
// Summary of operation
// R01 - A brief external low on the shared start line triggers one reading that is stored.
// R02 - A self-started cycle drives the start line low and releases it when polarizing ends.
// R03 - An external low on the start line, short or long, starts a measurement cycle.
// R04 - After a momentary external low, polarizing ends at the configured time.
// R05 - While the external low persists, polarizing continues and counting waits for release.
// R06 - Two units sharing the line run in step and either may start the cycle.
// R07 - Every reading polarizes first, then removes current and counts for a window.
// R08 - The long-polarize switch stretches polarizing from under two to almost three seconds.
// R09 - The short-polarize switch cuts polarizing below one second and wins over long.
// R10 - The count window is 920 ms, or 460 ms with the short-count switch on.
// R11 - The short-count switch halves the reported resolution to 0.2 nT.
// R12 - The averaging switch makes each cycle take three readings and report their mean.
// R13 - A signal collapse inside the count window drops the last digit and gives five beeps.
// R14 - Switches one to five default off, six to eight on; six to eight pick the baud rate.
// R15 - In automatic mode with display blanking, five idle keyboard minutes blank the display.
// R16 - The sensed line is synchronised and debounced, and the own drive is not seen as external.
package mcsc_pkg;
  localparam int          ADDR_W          = 5;
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          TICK_NS         = 1000000;
  localparam int          TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  localparam int          DEBOUNCE_NS     = 20000;
  localparam logic [11:0] DEBOUNCE_CYC    = 12'(DEBOUNCE_NS / CLK_PERIOD_NS);
  localparam logic [11:0] POL_NORMAL_MS   = 12'h708;
  localparam logic [11:0] POL_LONG_MS     = 12'hB54;
  localparam logic [11:0] POL_SHORT_MS    = 12'h384;
  localparam logic [11:0] COUNT_NORMAL_MS = 12'h398;
  localparam logic [11:0] COUNT_SHORT_MS  = 12'h1CC;
  localparam logic [18:0] DISPLAY_IDLE_MS = 19'h493E0;
  localparam logic [6:0]  BEEP_MS         = 7'h32;
  localparam logic [2:0]  BEEP_COUNT      = 3'h5;
  localparam logic [1:0]  AVG_LAST        = 2'h2;
  localparam logic [19:0] DIV3_MUL        = 20'hAAAAB;
  localparam logic [7:0]  SWITCH_DEFAULT  = 8'hE0;
  localparam logic [12:0] PIN_RESET       = 13'h1C10;
  localparam logic [4:0]  REG_CTRL        = 5'h00;
  localparam logic [4:0]  REG_AUTO_MS     = 5'h04;
  localparam logic [4:0]  REG_STATUS      = 5'h08;
  localparam logic [4:0]  REG_RESULT      = 5'h0C;
  localparam logic [4:0]  REG_IRQ_STATUS  = 5'h10;
  localparam logic [4:0]  REG_IRQ_CLEAR   = 5'h14;
  localparam logic [4:0]  REG_IRQ_ENABLE  = 5'h18;
  localparam logic [15:0] AUTO_MS_RESET   = 16'h1388;
  typedef enum logic [2:0] {ST_IDLE, ST_POLARIZE, ST_HOLD, ST_COUNT, ST_DONE} mcsc_state_t;
endpackage

// File: mcsc_top.sv
// Measurement cycle sequencer: polarize, count, shared start line, switches, registers.
// Assumes pins are asynchronous and the start line is open drain with an external pull-up.
module mcsc_top #(
  parameter int TICK_CYCLES = mcsc_pkg::TICK_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic [mcsc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        sync_in,
  output logic                             sync_out,
  output logic                             sync_oe,
  input  wire logic                        read_key,
  input  wire logic                        key_activity,
  input  wire logic                        precession_in,
  input  wire logic                        signal_present,
  input  wire logic [7:0]                  switch_in,
  output logic                             polarize_on,
  output logic                             count_active,
  output logic                             reading_stored,
  output logic                             digit_drop,
  output logic                             half_resolution,
  output logic                             beep,
  output logic                             display_on,
  output logic [2:0]                       baud_code,
  output logic                             irq
);
  import mcsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and debounce
  logic [12:0] pin_meta, pin_sync, pin_prev;
  logic        line_high, next_line_high;
  logic [11:0] deb_cnt, next_deb_cnt;
  logic [12:0] holdoff, next_holdoff;
  logic        ext_low, ext_low_d;
  logic [7:0]  sw;
  logic        key_rise, act_rise, prec_rise, ext_fall, sig_ok;

  assign sw        = pin_sync[12:5];
  assign key_rise  = pin_sync[3] & ~pin_prev[3];
  assign act_rise  = pin_sync[2] & ~pin_prev[2];
  assign prec_rise = pin_sync[1] & ~pin_prev[1];
  assign sig_ok    = pin_sync[0];
  assign ext_low   = ~line_high & ~sync_oe & (holdoff == 13'h0000); // [R16]
  assign ext_fall  = ext_low & ~ext_low_d;

  always_comb begin
    next_line_high = line_high;
    next_deb_cnt   = 12'h000;
    if (pin_sync[4] != line_high) begin // [R16]
      next_deb_cnt = deb_cnt + 12'h001;
      if (deb_cnt == DEBOUNCE_CYC - 12'h001) begin
        next_line_high = pin_sync[4];
        next_deb_cnt   = 12'h000;
      end
    end
    next_holdoff = (holdoff != 13'h0000) ? holdoff - 13'h0001 : 13'h0000;
    if (sync_oe) begin
      next_holdoff = {1'b0, DEBOUNCE_CYC} + {1'b0, DEBOUNCE_CYC};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_meta  <= PIN_RESET;
      pin_sync  <= PIN_RESET;
      pin_prev  <= PIN_RESET;
      line_high <= 1'b1;
      deb_cnt   <= 12'h000;
      holdoff   <= 13'h0000;
      ext_low_d <= 1'b0;
    end else begin
      pin_meta  <= {switch_in, sync_in, read_key, key_activity, precession_in, signal_present};
      pin_sync  <= pin_meta;
      pin_prev  <= pin_sync;
      line_high <= next_line_high;
      deb_cnt   <= next_deb_cnt;
      holdoff   <= next_holdoff;
      ext_low_d <= ext_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  logic [31:0] tick_cnt, next_tick_cnt;
  logic        tick;
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
  always_comb next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer
  mcsc_state_t state, next_state;
  logic [11:0] phase_ms, next_phase_ms, pol_len, count_len;
  logic        self_start, next_self_start, auto_en, soft_read;
  logic [1:0]  idx, next_idx;
  logic [15:0] count_acc, next_count_acc, result, next_result, auto_ms, next_auto_ms;
  logic [15:0] auto_interval;
  logic [17:0] sum, next_sum;
  logic [37:0] div_prod;
  logic        trunc, next_trunc, next_drop, next_stored;
  logic [2:0]  beeps_left, next_beeps_left;
  logic [6:0]  beep_ms, next_beep_ms;
  logic        next_beep;
  logic [18:0] idle_ms, next_idle_ms;
  logic        start, end_read;

  assign pol_len   = sw[1] ? POL_SHORT_MS : (sw[0] ? POL_LONG_MS : POL_NORMAL_MS); // [R08] [R09]
  assign count_len = sw[2] ? COUNT_SHORT_MS : COUNT_NORMAL_MS; // [R10]
  assign div_prod  = sum * DIV3_MUL;
  assign start     = ext_fall | key_rise | soft_read | (auto_en & (auto_ms >= auto_interval));
  assign end_read  = (state == ST_COUNT) &&
                     (~sig_ok || (tick && phase_ms == count_len - 12'h001));

  always_comb begin
    next_state      = state;
    next_phase_ms   = (tick && state != ST_IDLE) ? phase_ms + 12'h001 : phase_ms;
    next_self_start = self_start;
    next_idx        = idx;
    next_count_acc  = count_acc;
    next_sum        = sum;
    next_result     = result;
    next_trunc      = trunc;
    next_drop       = digit_drop;
    next_stored     = 1'b0;
    next_auto_ms    = (state == ST_IDLE && tick && auto_en) ? auto_ms + 16'h0001 : auto_ms;
    unique case (state)
      ST_IDLE: begin
        if (start) begin // [R01] [R03] [R06]
          next_state      = ST_POLARIZE;
          next_self_start = ~ext_fall;
          next_phase_ms   = 12'h000;
          next_idx        = 2'h0;
          next_sum        = 18'h0;
          next_trunc      = 1'b0;
          next_auto_ms    = 16'h0000;
        end
      end
      ST_POLARIZE: begin
        if (tick && phase_ms == pol_len - 12'h001) begin // [R04] [R07]
          next_phase_ms  = 12'h000;
          next_count_acc = 16'h0000;
          next_state     = (~self_start && ext_low) ? ST_HOLD : ST_COUNT; // [R05]
        end
      end
      ST_HOLD: begin
        next_phase_ms = 12'h000;
        if (!ext_low) begin // [R05]
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (prec_rise) begin
          next_count_acc = count_acc + 16'h0001;
        end
        if (end_read) begin // [R07]
          next_trunc    = trunc | ~sig_ok; // [R13]
          next_sum      = sum + {2'h0, count_acc};
          next_phase_ms = 12'h000;
          if (sw[3] && idx != AVG_LAST) begin // [R12]
            next_idx   = idx + 2'h1;
            next_state = ST_POLARIZE;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        next_result = sw[3] ? div_prod[36:21] : sum[15:0]; // [R12]
        next_drop   = trunc; // [R13]
        next_stored = 1'b1; // [R01]
        next_state  = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    next_beeps_left = beeps_left;
    next_beep_ms    = beep_ms;
    next_beep       = beep;
    if (state == ST_DONE && trunc) begin // [R13]
      next_beeps_left = BEEP_COUNT;
      next_beep_ms    = 7'h00;
      next_beep       = 1'b1;
    end else if (beeps_left != 3'h0 && tick) begin
      next_beep_ms = beep_ms + 7'h01;
      if (beep_ms == BEEP_MS - 7'h01) begin
        next_beep_ms = 7'h00;
        next_beep    = ~beep;
        if (beep) begin
          next_beeps_left = beeps_left - 3'h1;
        end
      end
    end
    next_idle_ms = idle_ms;
    if (act_rise || key_rise) begin
      next_idle_ms = 19'h0;
    end else if (tick && idle_ms < DISPLAY_IDLE_MS) begin
      next_idle_ms = idle_ms + 19'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_cnt        <= 32'h0;
      state           <= ST_IDLE;
      phase_ms        <= 12'h000;
      self_start      <= 1'b0;
      idx             <= 2'h0;
      count_acc       <= 16'h0000;
      sum             <= 18'h0;
      result          <= 16'h0000;
      trunc           <= 1'b0;
      digit_drop      <= 1'b0;
      reading_stored  <= 1'b0;
      auto_ms         <= 16'h0000;
      beeps_left      <= 3'h0;
      beep_ms         <= 7'h00;
      beep            <= 1'b0;
      idle_ms         <= 19'h0;
      polarize_on     <= 1'b0;
      count_active    <= 1'b0;
      sync_oe         <= 1'b0;
      sync_out        <= 1'b0;
      display_on      <= 1'b1;
      half_resolution <= 1'b0;
      baud_code       <= SWITCH_DEFAULT[7:5];
    end else begin
      tick_cnt        <= next_tick_cnt;
      state           <= next_state;
      phase_ms        <= next_phase_ms;
      self_start      <= next_self_start;
      idx             <= next_idx;
      count_acc       <= next_count_acc;
      sum             <= next_sum;
      result          <= next_result;
      trunc           <= next_trunc;
      digit_drop      <= next_drop;
      reading_stored  <= next_stored;
      auto_ms         <= next_auto_ms;
      beeps_left      <= next_beeps_left;
      beep_ms         <= next_beep_ms;
      beep            <= next_beep;
      idle_ms         <= next_idle_ms;
      polarize_on     <= next_state == ST_POLARIZE || next_state == ST_HOLD; // [R07]
      count_active    <= next_state == ST_COUNT;
      sync_oe         <= next_state == ST_POLARIZE && next_self_start; // [R02] [R06]
      sync_out        <= 1'b0;
      display_on      <= ~(auto_en && sw[4] && idle_ms >= DISPLAY_IDLE_MS); // [R15]
      half_resolution <= sw[2]; // [R11]
      baud_code       <= sw[7:5]; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave and interrupts
  logic        next_wait, wr_en, next_soft_read, next_auto_en, next_irq;
  logic [31:0] next_readdata;
  logic [15:0] next_auto_interval;
  logic [2:0]  irq_status, irq_enable, next_irq_status, next_irq_enable, events;

  assign wr_en  = avs_write & ~avs_waitrequest;
  assign events = {next_drop & (state == ST_DONE), ext_fall & (state == ST_IDLE), next_stored};

  always_comb begin
    next_wait          = ~((avs_read | avs_write) & avs_waitrequest);
    next_readdata      = avs_readdata;
    next_soft_read     = wr_en && avs_address == REG_CTRL && avs_writedata[1];
    next_auto_en       = auto_en;
    next_auto_interval = auto_interval;
    next_irq_enable    = irq_enable;
    next_irq_status    = irq_status;
    if (wr_en) begin
      unique case (avs_address)
        REG_CTRL:       next_auto_en       = avs_writedata[0];
        REG_AUTO_MS:    next_auto_interval = avs_writedata[15:0];
        REG_IRQ_CLEAR:  next_irq_status    = irq_status & ~avs_writedata[2:0];
        REG_IRQ_ENABLE: next_irq_enable    = avs_writedata[2:0];
        default:        next_irq_enable    = irq_enable;
      endcase
    end
    next_irq_status = next_irq_status | events;
    next_irq        = |(irq_status & irq_enable);
    if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        REG_CTRL:       next_readdata = {31'h0, auto_en};
        REG_AUTO_MS:    next_readdata = {16'h0, auto_interval};
        REG_STATUS:     next_readdata = {18'h0, idx, display_on, digit_drop, count_active,
                                         polarize_on, sw};
        REG_RESULT:     next_readdata = {16'h0, result};
        REG_IRQ_STATUS: next_readdata = {29'h0, irq_status};
        REG_IRQ_ENABLE: next_readdata = {29'h0, irq_enable};
        default:        next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      soft_read       <= 1'b0;
      auto_en         <= 1'b0;
      auto_interval   <= AUTO_MS_RESET;
      irq_status      <= 3'h0;
      irq_enable      <= 3'h0;
      irq             <= 1'b0;
    end else begin
      avs_waitrequest <= next_wait;
      avs_readdata    <= next_readdata;
      soft_read       <= next_soft_read;
      auto_en         <= next_auto_en;
      auto_interval   <= next_auto_interval;
      irq_status      <= next_irq_status;
      irq_enable      <= next_irq_enable;
      irq             <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  own_drive_a: assert property (sync_oe |-> polarize_on && self_start) // [R02]
    else $error("start line driven outside self-started polarize");
  release_a: assert property ($fell(polarize_on) && $past(sync_oe) |-> !sync_oe) // [R02]
    else $error("start line not released at polarize end");
  ext_start_a: assert property (state == ST_IDLE && ext_fall |=> state == ST_POLARIZE) // [R03]
    else $error("external low did not start a cycle");
  hold_polar_a: assert property (state == ST_HOLD |-> polarize_on) // [R05]
    else $error("polarize current dropped while line held");
  hold_exit_a: assert property (state == ST_HOLD && !ext_low |=> state == ST_COUNT) // [R05]
    else $error("count did not follow line release");
  phase_order_a: assert property ($rose(count_active) |-> $past(polarize_on, 1)) // [R07]
    else $error("count began without polarize");
  short_pol_a: assert property (state == ST_POLARIZE && sw[1] |-> phase_ms < POL_SHORT_MS) // [R09]
    else $error("short polarize overran");
  window_a: assert property (state == ST_COUNT |-> phase_ms < count_len) // [R10]
    else $error("count window overran");
  own_mask_a: assert property (sync_oe |-> !ext_low) // [R16]
    else $error("own drive seen as external");
  beeps_a: assert property ($rose(digit_drop) |-> beeps_left == BEEP_COUNT && beep) // [R13]
    else $error("collapse without five beeps");
  avg_idx_a: assert property (!sw[3] && state == ST_COUNT |-> idx == 2'h0) // [R12]
    else $error("extra reading without averaging");
  blank_a: assert property (!display_on |-> $past(auto_en && sw[4])) // [R15]
    else $error("display blanked outside auto blank mode");

  self_cyc_c: cover property ($fell(sync_oe) && $rose(count_active));
  ext_hold_c: cover property (state == ST_HOLD ##1 state == ST_COUNT);
  avg_done_c: cover property (idx == AVG_LAST && reading_stored);
  trunc_c:    cover property ($rose(digit_drop));
endmodule

// File: mcsc_line_partner.sv
// Far-side model of the shared start line: push-button, controller or second unit.
// Assumes an external pull-up on the line and the bench clock for its timing.
module mcsc_line_partner (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        press,
  input  wire logic [15:0] press_len,
  input  wire logic        sync_out,
  input  wire logic        sync_oe,
  output logic             line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] low_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Pull the line low for press_len cycles
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      low_cnt <= 16'h0000;
    end else if (press) begin
      low_cnt <= press_len;
    end else if (low_cnt != 16'h0000) begin
      low_cnt <= low_cnt - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Open drain: pull-up unless either party pulls low
  assign line = ~((low_cnt != 16'h0000) | (sync_oe & ~sync_out));
endmodule

// File: mcsc_top_tb.sv
// Self-checking bench for the measurement cycle sequencer.
// Assumes the line partner model and a shortened millisecond tick.
module mcsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcsc_pkg::*;
  localparam int TK = 10;
  logic        ref_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        sync_in, sync_out, sync_oe, read_key, precession_in, signal_present;
  logic [7:0]  switch_in;
  logic        polarize_on, count_active, reading_stored, digit_drop, half_resolution;
  logic        beep, display_on, irq, press, beep_q, overlap;
  logic [2:0]  baud_code, ph;
  logic [15:0] press_len;
  int          n_fail, n_tests, pol_c, pol_len, cnt_c, cnt_len, oe_c, oe_len, n_stored, n_beep;

  mcsc_top #(.TICK_CYCLES(TK)) u_mcsc_top (
    .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sync_in(sync_in), .sync_out(sync_out),
    .sync_oe(sync_oe), .read_key(read_key), .key_activity(1'b0),
    .precession_in(precession_in), .signal_present(signal_present), .switch_in(switch_in),
    .polarize_on(polarize_on), .count_active(count_active), .reading_stored(reading_stored),
    .digit_drop(digit_drop), .half_resolution(half_resolution), .beep(beep),
    .display_on(display_on), .baud_code(baud_code), .irq(irq));
  mcsc_line_partner u_mcsc_line_partner (
    .ref_clk(ref_clk), .reset(reset), .press(press), .press_len(press_len),
    .sync_out(sync_out), .sync_oe(sync_oe), .line(sync_in));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, precession stimulus and phase monitor
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    ph <= ph + 3'h1;
    precession_in <= ph[2];
    if (polarize_on === 1'b1) pol_c++; else if (pol_c != 0) begin pol_len = pol_c; pol_c = 0; end
    if (count_active === 1'b1) cnt_c++; else if (cnt_c != 0) begin cnt_len = cnt_c; cnt_c = 0; end
    if (sync_oe === 1'b1) oe_c++; else if (oe_c != 0) begin oe_len = oe_c; oe_c = 0; end
    if (reading_stored === 1'b1) n_stored++;
    if (beep === 1'b1 && beep_q !== 1'b1) n_beep++;
    beep_q = beep;
    if (polarize_on === 1'b1 && count_active === 1'b1) overlap = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_in(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    k = 0;
    do begin @(posedge ref_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk({31'h0, k < 50}, 32'h1);
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic wait_stored(input int n);
    int k;
    k = 0;
    while (n_stored < n && k < 40000) begin cyc(1); k++; end
    chk(n_stored, n);
  endtask
  task automatic kick;
    read_key <= 1'b1;
    cyc(10);
    read_key <= 1'b0;
  endtask
  task automatic ext_low(input logic [15:0] n);
    press_len <= n;
    press <= 1'b1;
    cyc(1);
    press <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_regs;
    chk({display_on, baud_code, polarize_on, sync_oe, irq}, 32'h78);
    rd(REG_AUTO_MS, 32'h1388);
    rd(5'h1C, 32'h0);
    rd(REG_IRQ_CLEAR, 32'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[7:0], 8'hE0);
    bus(1'b1, REG_AUTO_MS, 32'hAB);
    rd(REG_AUTO_MS, 32'hAB);
  endtask
  task automatic t_switches;
    for (int k = 0; k < 8; k++) begin
      switch_in <= {3'(k), 5'h02};
      cyc(6);
      chk({baud_code, half_resolution}, {3'(k), 1'b0});
    end
    switch_in <= 8'hE6;
    cyc(6);
    chk(half_resolution, 1'b1);
  endtask
  task automatic t_manual;
    bus(1'b1, REG_IRQ_ENABLE, 32'h1);
    kick();
    wait_stored(1);
    chk_in(pol_len, 900 * TK - TK, 900 * TK + TK);
    chk(oe_len, pol_len);
    chk_in(cnt_len, 460 * TK - TK, 460 * TK + TK);
    chk(overlap, 1'b0);
    cyc(3);
    chk(irq, 1'b1);
    rd(REG_IRQ_STATUS, 32'h1);
    bus(1'b1, REG_IRQ_ENABLE, 32'h0);
    cyc(3);
    chk(irq, 1'b0);
    bus(1'b1, REG_IRQ_CLEAR, 32'h7);
    rd(REG_IRQ_STATUS, 32'h0);
  endtask
  task automatic t_ext_pulse;
    cyc(1000);
    oe_len = 0;
    ext_low(16'd3000);
    wait_stored(2);
    chk(oe_len, 0);
    chk_in(pol_len, 900 * TK - TK, 900 * TK + TK);
    rd(REG_IRQ_STATUS, 32'h3);
    bus(1'b1, REG_IRQ_CLEAR, 32'h7);
  endtask
  task automatic t_sustained;
    cyc(1000);
    ext_low(16'd16000);
    wait_stored(3);
    chk_in(pol_len, 16000 - 2600, 16000 + 600);
    chk_in(cnt_len, 460 * TK - TK, 460 * TK + TK);
  endtask
  task automatic t_collapse;
    int k;
    switch_in <= 8'hE5;
    bus(1'b1, REG_IRQ_CLEAR, 32'h7);
    bus(1'b1, REG_IRQ_ENABLE, 32'h4);
    n_beep = 0;
    kick();
    k = 0;
    while (count_active !== 1'b1 && k < 40000) begin cyc(1); k++; end
    signal_present <= 1'b0;
    wait_stored(4);
    signal_present <= 1'b1;
    chk_in(pol_len, 2900 * TK - TK, 2900 * TK + TK);
    cyc(5500);
    chk(n_beep, 5);
    chk(digit_drop, 1'b1);
    rd(REG_IRQ_STATUS, 32'h5);
    chk(irq, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Run control
  task automatic end_of_test;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (99000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    {n_fail, n_tests, pol_c, pol_len, cnt_c, cnt_len, oe_c, oe_len, n_stored, n_beep} = '0;
    {avs_read, avs_write, read_key, press, beep_q, overlap} = '0;
    {avs_address, avs_writedata, press_len, ph, precession_in} = '0;
    reset = 1'b1;
    signal_present = 1'b1;
    switch_in = 8'hE0;
    cyc(6);
    reset <= 1'b0;
    cyc(1);
    t_reset_regs();
    t_switches();
    t_manual();
    t_ext_pulse();
    t_sustained();
    t_collapse();
    end_of_test();
  end
endmodule
